/* File: hw/smc_pkg.sv */
// Constants and types shared by the sleep controller design files
package smc_pkg;

  // Control register layout
  localparam int CTRL_SE_BIT = 7;
  localparam int CTRL_SK_HI  = 6;
  localparam int CTRL_SK_LO  = 4;

  // Sleep-kind codes
  localparam logic [2:0] SK_IDLE    = 3'h0;
  localparam logic [2:0] SK_NOISE   = 3'h1;
  localparam logic [2:0] SK_PWRDOWN = 3'h2;
  localparam logic [2:0] SK_PWRSAVE = 3'h3;
  localparam logic [2:0] SK_STANDBY = 3'h6;

  // Timing: extra core hold after start-up, standby resume time
  localparam logic [7:0] HOLD_CYCLES    = 8'h04;
  localparam logic [7:0] STANDBY_CYCLES = 8'h06;
  localparam logic [7:0] CNT_ONE        = 8'h01;
  localparam logic [7:0] CNT_ZERO       = 8'h00;

  // Clock-source fuse values naming an external crystal or resonator
  localparam logic [3:0] FUSE_XTAL_MIN = 4'h9;

  // External RC fuse range and the restart delays in the table
  localparam logic [3:0] FUSE_RC_MIN = 4'h5;
  localparam logic [3:0] FUSE_RC_MAX = 4'h8;
  localparam logic [7:0] DLY_RC      = 8'h12;
  localparam logic [7:0] DLY_FAST    = 8'h06;

  // Restart delay table depth and entry width
  localparam int DLY_ENTRIES = 16;
  localparam int DLY_W       = 8;

  typedef enum logic [2:0] {
    SMC_RUN, SMC_SLEEP, SMC_RESTART, SMC_HOLD
  } smc_state_t;

endpackage : smc_pkg

/* File: hw/smc_delay_rom.sv */
// Restart delay table indexed by the clock-source fuses, registered read
`timescale 1ns/100ps
module smc_delay_rom (
  // Clock
  input  wire logic       ref_clk_in,
  // Lookup
  input  wire logic [3:0] fuse_in,
  output logic      [7:0] delay_out
);
  logic [7:0] table_q [smc_pkg::DLY_ENTRIES];

  // Default 6 cycles for fast options, 18 for external RC range
  genvar g;
  generate
    for (g = 0; g < smc_pkg::DLY_ENTRIES; g++) begin : g_tab
      assign table_q[g] = (g >= smc_pkg::FUSE_RC_MIN && g <= smc_pkg::FUSE_RC_MAX) ?
                          smc_pkg::DLY_RC : smc_pkg::DLY_FAST;
    end
  endgenerate

  always_ff @(posedge ref_clk_in) begin
    delay_out <= table_q[fuse_in];
  end
endmodule // smc_delay_rom

/* File: hw/smc_ctrl.sv */
// Sleep mode controller: clock gating and wake-up sequencing
// Function
// - Sleep entered only with sleep-enable set and sleep instruction executed
// - Interrupt wake holds core four cycles past start-up, then resumes
// - Register file and static memory kept intact across sleep
// - Reset during sleep leaves sleep and restarts from reset vector
// - Code 000 Idle: only core and program-memory clocks stop
// - Idle wakes on external and internal interrupts
// - Converter enabled: Idle or noise mode entry starts one conversion
// - Code 001 noise mode: io, core, program-memory clocks stop
// - Noise mode wakes only on its listed sources
// - Code 010 power-down: oscillator and all generated clocks stop
// - Power-down wakes only on resets, address match, level interrupts
// - Power-down wake waits a fuse-selected clock restart delay
// - Code 011 power-save: like power-down, timer two may run and wake
// - Code 110 standby only with crystal; oscillator keeps running
// - Standby wake resumes after six clock cycles
// - Sleep-enable is control register bit 7
// - Sleep-kind code at bits 6:4; 100 and 101 reserved
`timescale 1ns/100ps
module smc_ctrl (
  // Clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       rst_n_in,
  // Core side
  input  wire logic [7:0] mcu_power_ctrl_reg_in,
  input  wire logic       sleep_instr_in,
  input  wire logic       adc_enable_in,
  input  wire logic       timer2_external_clock_bit_in,
  input  wire logic       global_irq_en_in,
  input  wire logic [3:0] clock_source_fuses_in,
  // Wake-up sources (asynchronous pins, synchronised here)
  input  wire logic       any_irq_in,
  input  wire logic       adc_done_irq_in,
  input  wire logic       twi_match_irq_in,
  input  wire logic       timer2_irq_in,
  input  wire logic       nvm_ready_irq_in,
  input  wire logic       ext_irq_line0_in,
  input  wire logic       ext_irq_line1_in,
  input  wire logic       ext_level_mode_in,
  input  wire logic       sys_reset_req_in,
  // Clock gates and status
  output logic            core_clock_en_out,
  output logic            program_mem_clock_en_out,
  output logic            io_clock_en_out,
  output logic            converter_clock_en_out,
  output logic            watch_crystal_clock_en_out,
  output logic            main_osc_en_out,
  output logic            adc_start_out,
  output logic            run_irq_out,
  output logic            reset_vector_out,
  output logic            sleeping_out
);
  localparam int NSRC = 9;

  smc_pkg::smc_state_t state;
  logic [2:0]      mode;
  logic [7:0]      cnt;
  logic [7:0]      fuse_delay;
  logic [NSRC-1:0] src_raw;
  logic [NSRC-1:0] sync1;
  logic [NSRC-1:0] sync2;
  logic            ext_level;
  logic            xtal_sel;
  logic [2:0]      code;
  logic            go_sleep;
  logic            wake;

  assign src_raw = {sys_reset_req_in, ext_irq_line1_in, ext_irq_line0_in, nvm_ready_irq_in,
                    timer2_irq_in, twi_match_irq_in, adc_done_irq_in, any_irq_in,
                    ext_level_mode_in};

  // Two-flop synchronisers on every asynchronous wake-up pin
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_sync
      always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
        end else begin
          sync1[g] <= src_raw[g];
          sync2[g] <= sync1[g];
        end
      end
    end
  endgenerate

  // Level wake needs the line low for the synchroniser depth
  assign ext_level = sync2[0] & (~sync2[6] | ~sync2[7]);

  smc_delay_rom u_rom (
    .ref_clk_in (ref_clk_in),
    .fuse_in    (clock_source_fuses_in),
    .delay_out  (fuse_delay)
  );

  function automatic logic code_ok(input logic [2:0] c, input logic xtal);
    code_ok = (c == smc_pkg::SK_IDLE) || (c == smc_pkg::SK_NOISE) ||
              (c == smc_pkg::SK_PWRDOWN) || (c == smc_pkg::SK_PWRSAVE) ||
              ((c == smc_pkg::SK_STANDBY) && xtal);
  endfunction

  assign xtal_sel = clock_source_fuses_in >= smc_pkg::FUSE_XTAL_MIN;
  assign code     = mcu_power_ctrl_reg_in[smc_pkg::CTRL_SK_HI:smc_pkg::CTRL_SK_LO];
  assign go_sleep = sleep_instr_in && mcu_power_ctrl_reg_in[smc_pkg::CTRL_SE_BIT] &&
                    code_ok(code, xtal_sel);

  // Wake-up source filter per mode
  always_comb begin
    case (mode)
      smc_pkg::SK_IDLE:    wake = sync2[1];
      smc_pkg::SK_NOISE:   wake = sync2[2] | sync2[3] | sync2[4] | sync2[5] | ext_level;
      smc_pkg::SK_PWRSAVE: wake = sync2[3] | ext_level |
                                  (sync2[4] & timer2_external_clock_bit_in &
                                   global_irq_en_in);
      default:             wake = sync2[3] | ext_level;
    endcase
  end

  // Sequencer; resets from any source win over wake-ups
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      state <= smc_pkg::SMC_RUN;
      mode  <= smc_pkg::SK_IDLE;
      cnt   <= smc_pkg::CNT_ZERO;
    end else if (sync2[8] && state != smc_pkg::SMC_RUN) begin
      state <= smc_pkg::SMC_RUN;
      cnt   <= smc_pkg::CNT_ZERO;
    end else begin
      case (state)
        smc_pkg::SMC_RUN: begin
          if (go_sleep) begin
            state <= smc_pkg::SMC_SLEEP;
            mode  <= code;
          end
        end
        smc_pkg::SMC_SLEEP: begin
          if (wake) begin
            state <= smc_pkg::SMC_RESTART;
            if (mode == smc_pkg::SK_STANDBY)
              cnt <= smc_pkg::STANDBY_CYCLES;
            else if (mode == smc_pkg::SK_PWRDOWN || mode == smc_pkg::SK_PWRSAVE)
              cnt <= fuse_delay;
            else
              cnt <= smc_pkg::CNT_ONE;
          end
        end
        smc_pkg::SMC_RESTART: begin
          if (cnt <= smc_pkg::CNT_ONE) begin
            state <= smc_pkg::SMC_HOLD;
            cnt   <= smc_pkg::HOLD_CYCLES;
          end else begin
            cnt <= cnt - smc_pkg::CNT_ONE;
          end
        end
        smc_pkg::SMC_HOLD: begin
          if (cnt <= smc_pkg::CNT_ONE) begin
            state <= smc_pkg::SMC_RUN;
            cnt   <= smc_pkg::CNT_ZERO;
          end else begin
            cnt <= cnt - smc_pkg::CNT_ONE;
          end
        end
        default: state <= smc_pkg::SMC_RUN;
      endcase
    end
  end

  // Clock gating outputs; memories are only gated, never reset, so contents survive
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      core_clock_en_out          <= 1'b1;
      program_mem_clock_en_out   <= 1'b1;
      io_clock_en_out            <= 1'b1;
      converter_clock_en_out     <= 1'b1;
      watch_crystal_clock_en_out <= 1'b1;
      main_osc_en_out            <= 1'b1;
      sleeping_out               <= 1'b0;
    end else begin
      core_clock_en_out          <= (state == smc_pkg::SMC_RUN);
      program_mem_clock_en_out   <= (state == smc_pkg::SMC_RUN);
      sleeping_out               <= (state != smc_pkg::SMC_RUN);
      if (state == smc_pkg::SMC_SLEEP) begin
        io_clock_en_out            <= (mode == smc_pkg::SK_IDLE);
        converter_clock_en_out     <= (mode == smc_pkg::SK_IDLE) ||
                                      (mode == smc_pkg::SK_NOISE);
        watch_crystal_clock_en_out <= (mode == smc_pkg::SK_IDLE) ||
                                      (mode == smc_pkg::SK_NOISE) ||
                                      ((mode == smc_pkg::SK_PWRSAVE) &&
                                       timer2_external_clock_bit_in);
        main_osc_en_out            <= (mode == smc_pkg::SK_IDLE) ||
                                      (mode == smc_pkg::SK_NOISE) ||
                                      (mode == smc_pkg::SK_STANDBY);
      end else begin
        io_clock_en_out            <= 1'b1;
        converter_clock_en_out     <= 1'b1;
        watch_crystal_clock_en_out <= 1'b1;
        main_osc_en_out            <= 1'b1;
      end
    end
  end

  // Conversion start, interrupt run and reset-vector pulses
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      adc_start_out    <= 1'b0;
      run_irq_out      <= 1'b0;
      reset_vector_out <= 1'b0;
    end else begin
      adc_start_out    <= (state == smc_pkg::SMC_RUN) && go_sleep && adc_enable_in &&
                          (code == smc_pkg::SK_IDLE || code == smc_pkg::SK_NOISE);
      run_irq_out      <= (state == smc_pkg::SMC_HOLD) && (cnt <= smc_pkg::CNT_ONE) &&
                          !sync2[8];
      reset_vector_out <= sync2[8] && (state != smc_pkg::SMC_RUN);
    end
  end

  // Assertions
  property p_enter;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (state == smc_pkg::SMC_RUN && sleep_instr_in &&
       !mcu_power_ctrl_reg_in[smc_pkg::CTRL_SE_BIT]) |=> state == smc_pkg::SMC_RUN;
  endproperty
  a_enter: assert property (p_enter) else $error("sleep without enable");

  property p_hold4;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (state == smc_pkg::SMC_RESTART && $past(state) == smc_pkg::SMC_RESTART ##0
       cnt <= smc_pkg::CNT_ONE && !sync2[8]) |=> (state == smc_pkg::SMC_HOLD)[*4];
  endproperty
  a_hold4: assert property (p_hold4) else $error("hold not four cycles");

  property p_rst;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (sync2[8] && state != smc_pkg::SMC_RUN) |=> state == smc_pkg::SMC_RUN && reset_vector_out;
  endproperty
  a_rst: assert property (p_rst) else $error("reset did not leave sleep");

  property p_idle_io;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (state == smc_pkg::SMC_SLEEP && mode == smc_pkg::SK_IDLE) |=>
        io_clock_en_out && !core_clock_en_out;
  endproperty
  a_idle_io: assert property (p_idle_io) else $error("idle gating wrong");

  property p_noise;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (state == smc_pkg::SMC_SLEEP && mode == smc_pkg::SK_NOISE) |=>
        !io_clock_en_out && converter_clock_en_out;
  endproperty
  a_noise: assert property (p_noise) else $error("noise gating wrong");

  property p_pd;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (state == smc_pkg::SMC_SLEEP && mode == smc_pkg::SK_PWRDOWN) |=>
        !main_osc_en_out && !converter_clock_en_out;
  endproperty
  a_pd: assert property (p_pd) else $error("power-down gating wrong");

  property p_pd_wake;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (state == smc_pkg::SMC_SLEEP && mode == smc_pkg::SK_PWRDOWN && !sync2[3] && !ext_level &&
       !sync2[8]) |=> state == smc_pkg::SMC_SLEEP;
  endproperty
  a_pd_wake: assert property (p_pd_wake) else $error("bad power-down wake");

  property p_stby;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (state == smc_pkg::SMC_SLEEP && mode == smc_pkg::SK_STANDBY && wake && !sync2[8]) |=>
        (state == smc_pkg::SMC_RESTART)[*6] ##1 state == smc_pkg::SMC_HOLD;
  endproperty
  a_stby: assert property (p_stby) else $error("standby resume not six");

  property p_rsv;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (state == smc_pkg::SMC_RUN && sleep_instr_in && code[2] && !code[1]) |=>
        state == smc_pkg::SMC_RUN;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved code slept");

  property p_adc;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (state == smc_pkg::SMC_RUN && go_sleep && !adc_enable_in) |=> !adc_start_out;
  endproperty
  a_adc: assert property (p_adc) else $error("conversion started while disabled");

  // In power-save, timer two may only wake when clocked externally and globally enabled
  property p_ps_wake;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (state == smc_pkg::SMC_SLEEP && mode == smc_pkg::SK_PWRSAVE && !sync2[3] && !ext_level &&
       !sync2[8] && !(timer2_external_clock_bit_in && global_irq_en_in)) |=>
        state == smc_pkg::SMC_SLEEP;
  endproperty
  a_ps_wake: assert property (p_ps_wake) else $error("bad power-save wake");

  c_idle: cover property (@(posedge ref_clk_in) state == smc_pkg::SMC_SLEEP &&
                          mode == smc_pkg::SK_IDLE);
  c_pd:   cover property (@(posedge ref_clk_in) state == smc_pkg::SMC_SLEEP &&
                          mode == smc_pkg::SK_PWRDOWN ##1 state == smc_pkg::SMC_RESTART);
  c_irq:  cover property (@(posedge ref_clk_in) run_irq_out);
  c_stby: cover property (@(posedge ref_clk_in) state == smc_pkg::SMC_SLEEP &&
                          mode == smc_pkg::SK_STANDBY ##1 state == smc_pkg::SMC_RESTART);
endmodule // smc_ctrl

/* File: sim/smc_core_model.sv */
// Model of the CPU core and the wake-up sources facing the sleep controller
`timescale 1ns/100ps
module smc_core_model (
  // Clock
  input  wire logic       ref_clk_in,
  // From the controller
  input  wire logic       core_clock_en_in,
  input  wire logic       run_irq_in,
  input  wire logic       reset_vector_in,
  // To the controller
  output logic            sleep_instr_out,
  output logic [7:0]      wake_src_out
);
  initial begin
    sleep_instr_out = 1'b0;
    wake_src_out    = 8'h00;
  end
  // A gated core cannot fetch, so it never issues the instruction then
  task automatic sleep_op();
    @(negedge ref_clk_in);
    sleep_instr_out = core_clock_en_in;
    @(negedge ref_clk_in);
    sleep_instr_out = 1'b0;
  endtask
  task automatic raise(input int idx);
    @(negedge ref_clk_in);
    wake_src_out[idx] = 1'b1;
  endtask
  // Sources hold their level until serviced, so a level wake is never lost
  always @(negedge ref_clk_in) begin
    if (run_irq_in || reset_vector_in) begin
      wake_src_out = 8'h00;
    end
  end
endmodule // smc_core_model

/* File: sim/tb_smc_ctrl.sv */
// Self-checking bench for the sleep controller
`timescale 1ns/100ps
module tb_smc_ctrl;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [3:0] fuse;
    logic       as2;
    logic [3:0] src;
    logic [5:0] gates;
    logic [7:0] rst;
    logic       adc;
  } smc_row_t;
  logic       ref_clk_in, rst_n_in, sleep_instr, as2, core_en, prog_en, io_en;
  logic       conv_en, watch_en, osc_en, adc_start, run_irq, reset_vec, sleeping;
  logic       rv, core_at_irq, adc_en, gie, lvl_mode;
  logic [7:0] ctrl, wake_src, starts, base;
  logic [3:0] fuse;
  logic [5:0] gates;
  int         bad_count, checked, lat;
  smc_row_t   rows [11];
  smc_row_t   r;
  assign gates = {core_en, prog_en, io_en, conv_en, watch_en, osc_en};
  smc_ctrl i_smc_ctrl (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .mcu_power_ctrl_reg_in(ctrl),
    .sleep_instr_in(sleep_instr), .adc_enable_in(adc_en),
    .timer2_external_clock_bit_in(as2), .global_irq_en_in(gie),
    .clock_source_fuses_in(fuse), .any_irq_in(wake_src[0]),
    .adc_done_irq_in(wake_src[1]), .twi_match_irq_in(wake_src[2]),
    .timer2_irq_in(wake_src[3]), .nvm_ready_irq_in(wake_src[4]),
    .ext_irq_line0_in(~wake_src[5]), .ext_irq_line1_in(~wake_src[6]),
    .ext_level_mode_in(lvl_mode), .sys_reset_req_in(wake_src[7]),
    .core_clock_en_out(core_en), .program_mem_clock_en_out(prog_en),
    .io_clock_en_out(io_en), .converter_clock_en_out(conv_en),
    .watch_crystal_clock_en_out(watch_en), .main_osc_en_out(osc_en),
    .adc_start_out(adc_start), .run_irq_out(run_irq),
    .reset_vector_out(reset_vec), .sleeping_out(sleeping));
  smc_core_model i_smc_core_model (
    .ref_clk_in(ref_clk_in), .core_clock_en_in(core_en), .run_irq_in(run_irq),
    .reset_vector_in(reset_vec), .sleep_instr_out(sleep_instr),
    .wake_src_out(wake_src));
  always #50 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) begin
    if (rst_n_in !== 1'b1) begin
      starts <= 8'h00;
    end else if (adc_start === 1'b1) begin
      starts <= starts + 8'h01;
    end
  end
  task automatic chk_v(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic chk_r(input string what, input int got, input int lo, input int hi);
    checked++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Bounded wait for either kind of wake; the core must still be gated then
  task automatic wait_wake();
    lat = 0;
    do begin
      @(negedge ref_clk_in);
      lat++;
    end while (lat < 60 && run_irq !== 1'b1 && reset_vec !== 1'b1);
    rv = reset_vec;
    core_at_irq = core_en;
  endtask
  // A source outside the mode's list must not wake; a listed one must
  task automatic denied(input logic [7:0] c, input int bad_src, input int ok_src);
    ctrl = c;
    i_smc_core_model.sleep_op();
    i_smc_core_model.raise(bad_src);
    repeat (40) @(negedge ref_clk_in);
    chk_v("still_asleep", 8'h01, {7'h00, sleeping});
    i_smc_core_model.raise(ok_src);
    wait_wake();
    chk_v("woke", 8'h01, {7'h00, run_irq});
    repeat (3) @(negedge ref_clk_in);
  endtask
  initial begin
    #2000000;
    bad_count++;
    close_out();
  end
  initial begin
    rows[0]  = '{8'h80, 4'h9, 1'b0, 4'h0, 6'h0F, 8'h01, 1'b1};
    rows[1]  = '{8'h90, 4'h9, 1'b0, 4'h1, 6'h07, 8'h01, 1'b1};
    rows[2]  = '{8'h90, 4'h9, 1'b0, 4'h4, 6'h07, 8'h01, 1'b1};
    rows[3]  = '{8'hA0, 4'h9, 1'b0, 4'h2, 6'h00, 8'h06, 1'b0};
    rows[4]  = '{8'hA0, 4'h5, 1'b0, 4'h5, 6'h00, 8'h12, 1'b0};
    rows[5]  = '{8'hB0, 4'h9, 1'b1, 4'h3, 6'h02, 8'h06, 1'b0};
    rows[6]  = '{8'hE0, 4'h9, 1'b0, 4'h6, 6'h01, 8'h06, 1'b0};
    rows[7]  = '{8'h20, 4'h9, 1'b0, 4'hF, 6'h3F, 8'h00, 1'b0};
    rows[8]  = '{8'hC0, 4'h9, 1'b0, 4'hF, 6'h3F, 8'h00, 1'b0};
    rows[9]  = '{8'hD0, 4'h9, 1'b0, 4'hF, 6'h3F, 8'h00, 1'b0};
    rows[10] = '{8'hE0, 4'h8, 1'b0, 4'hF, 6'h3F, 8'h00, 1'b0};
    ref_clk_in = 1'b0;
    rst_n_in = 1'b0;
    ctrl = 8'h00;
    as2 = 1'b0;
    fuse = 4'h9;
    adc_en = 1'b1;
    gie = 1'b1;
    lvl_mode = 1'b1;
    bad_count = 0;
    checked = 0;
    repeat (16) @(negedge ref_clk_in);
    chk_v("gates_rst", 8'h3F, {2'h0, gates});
    rst_n_in = 1'b1;
    repeat (3) @(negedge ref_clk_in);
    for (int i = 0; i < 11; i++) begin
      r = rows[i];
      ctrl = r.ctrl;
      fuse = r.fuse;
      as2 = r.as2;
      base = starts;
      i_smc_core_model.sleep_op();
      repeat (3) @(negedge ref_clk_in);
      chk_v("gates", {2'h0, r.gates}, {2'h0, gates});
      chk_v("sleeping", {7'h00, r.src != 4'hF}, {7'h00, sleeping});
      chk_v("adc_start", {7'h00, r.adc}, starts - base);
      if (r.src != 4'hF) begin
        i_smc_core_model.raise(r.src);
        wait_wake();
        chk_r("wake_lat", lat, r.rst + 7, r.rst + 7);
        chk_v("core_in_hold", 8'h00, {7'h00, core_at_irq});
        repeat (3) @(negedge ref_clk_in);
        chk_v("gates_back", 8'h3F, {2'h0, gates});
      end
    end
    fuse = 4'h9;
    as2 = 1'b0;
    denied(8'hA0, 3, 6);
    denied(8'hB0, 3, 2);
    as2 = 1'b1;
    gie = 1'b0;
    denied(8'hB0, 3, 2);
    gie = 1'b1;
    as2 = 1'b0;
    lvl_mode = 1'b0;
    denied(8'hA0, 5, 2);
    lvl_mode = 1'b1;
    adc_en = 1'b0;
    base = starts;
    denied(8'h90, 0, 2);
    chk_v("adc_off", 8'h00, starts - base);
    adc_en = 1'b1;
    ctrl = 8'hA0;
    i_smc_core_model.sleep_op();
    i_smc_core_model.raise(7);
    wait_wake();
    chk_v("reset_vec", 8'h01, {7'h00, rv});
    chk_r("reset_lat", lat, 2, 6);
    repeat (3) @(negedge ref_clk_in);
    chk_v("gates_rv", 8'h3F, {2'h0, gates});
    // Second reset while asleep must restore every clock
    ctrl = 8'h80;
    i_smc_core_model.sleep_op();
    repeat (3) @(negedge ref_clk_in);
    rst_n_in = 1'b0;
    repeat (4) @(negedge ref_clk_in);
    chk_v("gates_rst2", 8'h3F, {2'h0, gates});
    chk_v("sleep_rst2", 8'h00, {7'h00, sleeping});
    rst_n_in = 1'b1;
    repeat (3) @(negedge ref_clk_in);
    close_out();
  end
endmodule // tb_smc_ctrl
